// file: rtl/sbsr_pkg.sv
// package for the status byte and service request block
package sbsr_pkg;
    localparam int SBSR_W = 8;
    // status byte field positions
    localparam int SBSR_TEST_SUM_BIT = 3;
    localparam int SBSR_MSG_AVAIL_BIT = 4;
    localparam int SBSR_EVENT_SUM_BIT = 5;
    localparam int SBSR_MASTER_BIT = 6;
    // writable bits of the service request enable
    localparam logic [7:0] SBSR_SRE_MASK = 8'h38;
    localparam logic [7:0] SBSR_SRE_RST = 8'h00;
    localparam logic [7:0] SBSR_REG_RST = 8'h00;

    // event sources and their enables
    typedef struct packed {
        logic [7:0] std_event;
        logic [7:0] event_enable;
        logic [7:0] test_status;
        logic [7:0] test_enable;
    } sbsr_src_t;

    // host access strobes
    typedef struct packed {
        logic sre_wr;
        logic [7:0] sre_wdata;
        logic std_event_rd;
        logic test_status_rd;
    } sbsr_cmd_t;
endpackage : sbsr_pkg

// file: rtl/sbsr_summary.sv
// any-enabled-bit summary of a status register and its enable
`timescale 1ns/10ps
module sbsr_summary #(
    parameter int W = 8
) (
    // register and enable
    input wire logic [W-1:0] status,
    input wire logic [W-1:0] enable,
    // summary
    output logic summary
);
    assign summary = |(status & enable);
endmodule : sbsr_summary

// file: rtl/sbsr_top.sv
// status byte, service request enable and service request line
//
// Contract
// - master summary set when enabled bit set
// - master summary recomputed on any change
// - event summary from enabled standard events
// - enabled summary raises request and master summary
// - message available follows pending output
// - test summary from enabled test status
// - test summary exists only in analyzer
// - serial poll bit6 request, query master
// - enable writable only for bits 5,4,3
// - master and request bits always zero in enable
// - service request line driven by request
// - event enable gates same position
// - test enable gates same position
// - reading event registers clears them
`timescale 1ns/10ps
module sbsr_top
    import sbsr_pkg::*;
#(
    parameter bit IS_ANALYZER = 1'b1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // event inputs, one-cycle set pulses; output_pending is a level
    input wire logic [7:0] std_event_set,
    input wire logic [7:0] test_status_set,
    input wire logic output_pending,
    // enables from the command layer
    input wire logic [7:0] event_enable_in,
    input wire logic [7:0] test_enable_in,
    // host access
    input wire sbsr_pkg::sbsr_cmd_t cmd,
    // readback
    output logic [7:0] std_event_rdata,
    output logic [7:0] test_status_rdata,
    output logic [7:0] service_request_enable,
    output logic [7:0] status_byte_query,
    output logic [7:0] status_byte_poll,
    // gpib service request, open drain
    output logic srq_o,
    output logic srq_oe
);
    import sbsr_pkg::*;

    typedef struct packed {
        logic [7:0] std_event;
        logic [7:0] test_status;
        logic [7:0] sre;
        logic [7:0] event_enable;
        logic [7:0] test_enable;
        logic [7:0] query_q;
        logic [7:0] poll_q;
        logic [7:0] sev_rd;
        logic [7:0] tst_rd;
        logic srq;
    } sbsr_state_t;

    sbsr_state_t st_q;
    sbsr_state_t st_d;
    logic event_sum;
    logic test_sum_raw;
    logic [7:0] sb;
    logic master_sum;

    // event summary, same bit position gating
    sbsr_summary #(.W(SBSR_W)) u_event_sum (
        .status(st_q.std_event),
        .enable(st_q.event_enable),
        .summary(event_sum)
    );

    sbsr_summary #(.W(SBSR_W)) u_test_sum (
        .status(st_q.test_status),
        .enable(st_q.test_enable),
        .summary(test_sum_raw)
    );

    always_comb begin
        sb = SBSR_REG_RST;
        sb[SBSR_EVENT_SUM_BIT] = event_sum;
        sb[SBSR_MSG_AVAIL_BIT] = output_pending;
        sb[SBSR_TEST_SUM_BIT] = IS_ANALYZER ? test_sum_raw : 1'b0;
        // master and request have no enable of their own
        master_sum = |(sb & st_q.sre & SBSR_SRE_MASK);
    end

    always_comb begin
        st_d = st_q;
        st_d.event_enable = event_enable_in;
        st_d.test_enable = IS_ANALYZER ? test_enable_in : SBSR_REG_RST;
        // read clears, but a set in the same cycle survives
        st_d.std_event = (cmd.std_event_rd ? SBSR_REG_RST : st_q.std_event)
            | std_event_set;
        st_d.test_status = ((cmd.test_status_rd ? SBSR_REG_RST : st_q.test_status)
            | test_status_set) & (IS_ANALYZER ? 8'hFF : 8'h00);
        st_d.sev_rd = st_q.std_event;
        st_d.tst_rd = st_q.test_status;
        if (cmd.sre_wr) begin
            st_d.sre = cmd.sre_wdata & SBSR_SRE_MASK;
        end
        st_d.query_q = sb;
        st_d.query_q[SBSR_MASTER_BIT] = master_sum;
        st_d.poll_q = sb;
        st_d.poll_q[SBSR_MASTER_BIT] = master_sum;
        st_d.srq = master_sum;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign std_event_rdata = st_q.sev_rd;
    assign test_status_rdata = st_q.tst_rd;
    assign service_request_enable = st_q.sre;
    assign status_byte_query = st_q.query_q;
    assign status_byte_poll = st_q.poll_q;
    assign srq_o = 1'b0;
    assign srq_oe = st_q.srq;
endmodule : sbsr_top

// file: testbench/sbsr_properties.sv
// assertions on the status byte block ports
`timescale 1ns/10ps
module sbsr_properties
    import sbsr_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // watched
    input wire logic output_pending,
    input wire sbsr_pkg::sbsr_cmd_t cmd,
    input wire logic [7:0] service_request_enable,
    input wire logic [7:0] status_byte_query,
    input wire logic [7:0] status_byte_poll,
    input wire logic srq_o,
    input wire logic srq_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_poll_eq_query: assert property (status_byte_poll == status_byte_query) else $error("poll");
    a_undef_zero: assert property ((status_byte_query & 8'h87) == 8'h00) else $error("undef");
    a_sre_bits_only: assert property ((service_request_enable & 8'hc7) == 8'h00) else $error("sre");
    a_sre_write_mask: assert property (cmd.sre_wr |=>
        service_request_enable == ($past(cmd.sre_wdata) & 8'h38)) else $error("sre wr");
    a_master_summary: assert property (service_request_enable == $past(service_request_enable) |->
        status_byte_query[6] == |(status_byte_query[5:3] & service_request_enable[5:3]))
        else $error("master summary");
    a_srq_follows: assert property (srq_oe == status_byte_poll[6]) else $error("srq");
    a_srq_data_low: assert property (srq_oe |-> !srq_o) else $error("srq data");
    a_avail_tracks: assert property (status_byte_query[4] == $past(output_pending)) else $error("avail");
    c_srq: cover property (srq_oe);
    c_avail: cover property (status_byte_query[4]);
    c_wr: cover property (cmd.sre_wr);
endmodule : sbsr_properties
bind sbsr_top sbsr_properties u_sbsr_properties (.sys_clk, .rst_n, .output_pending, .cmd,
    .service_request_enable, .status_byte_query, .status_byte_poll, .srq_o, .srq_oe);

// file: testbench/sbsr_ctrl_model.sv
// bus controller model: pulled-up request line, serial poll on request
`timescale 1ns/10ps
module sbsr_ctrl_model (
    // request line and poll byte
    input wire logic srq_o,
    input wire logic srq_oe,
    input wire logic [7:0] poll,
    output logic srq_n,
    output logic [7:0] polled
);
    assign srq_n = srq_oe ? srq_o : 1'b1;
    assign polled = srq_n ? 8'h00 : poll;
endmodule : sbsr_ctrl_model

// file: testbench/sbsr_top_tb_top.sv
// self-checking bench for the status byte block
`timescale 1ns/10ps
module sbsr_top_tb_top;
    import sbsr_pkg::*;
    logic sys_clk = 0, rst_n = 0, output_pending = 0, srq_o, srq_oe, srq_n;
    logic [7:0] es = 0, ts = 0, ee = 0, te = 0, sre, q, p, pd, ser, test_status_register;
    sbsr_cmd_t cmd = '0;
    int miscompares = 0, n_tests = 0;
    always #25 sys_clk = ~sys_clk;
    sbsr_top u_sbsr_top (.sys_clk, .rst_n, .std_event_set(es), .test_status_set(ts),
        .output_pending, .event_enable_in(ee), .test_enable_in(te), .cmd,
        .std_event_rdata(ser), .test_status_rdata(test_status_register), .service_request_enable(sre),
        .status_byte_query(q), .status_byte_poll(p), .srq_o, .srq_oe);
    sbsr_ctrl_model u_sbsr_ctrl_model (.srq_o, .srq_oe, .poll(p), .srq_n, .polled(pd));
    task chk(input logic [7:0] s, input logic [7:0] e);
        n_tests++;
        if (s !== e) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task step(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : step
    task wr(input logic [7:0] v);
        cmd = '{1'b1, v, 1'b0, 1'b0};
        step(1);
        cmd = '0;
        step(2);
    endtask : wr
    task t_event;
        wr(8'hff);
        chk(sre, 8'h38);
        ee = 8'h04;
        es = 8'h04;
        step(1);
        es = 8'h00;
        step(2);
        chk(q, 8'h60);
        chk(pd, 8'h60);
        cmd.std_event_rd = 1'b1;
        step(1);
        cmd = '0;
        chk(ser, 8'h04);
        step(3);
        chk(q, 8'h00);
        chk({7'h0, srq_n}, 8'h01);
    endtask : t_event
    task t_mav_test;
        output_pending = 1'b1;
        wr(8'h08);
        chk(q, 8'h10);
        te = 8'h10;
        ts = 8'h10;
        step(1);
        ts = 8'h00;
        step(2);
        chk(q, 8'h58);
        cmd.test_status_rd = 1'b1;
        step(1);
        cmd = '0;
        chk(test_status_register, 8'h10);
        step(2);
        chk(q, 8'h10);
        chk({7'h0, srq_n}, 8'h01);
    endtask : t_mav_test
    task give_verdict;
        $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    initial begin
        #20us;
        miscompares++;
        give_verdict;
    end
    initial begin
        step(5);
        rst_n = 1'b1;
        step(1);
        chk(sre, 8'h00);
        t_event;
        t_mav_test;
        give_verdict;
    end
endmodule : sbsr_top_tb_top
